// File: spi_eeprom_params.svh
`ifndef SPI_EEPROM_PARAMS_SVH
`define SPI_EEPROM_PARAMS_SVH

// command opcodes, sent most significant bit first
`define OP_LATCH_SET      8'h06
`define OP_LATCH_CLEAR    8'h04
`define OP_STATE_READ     8'h05
`define OP_STATE_WRITE    8'h01
`define OP_ARRAY_READ     8'h03
`define OP_ARRAY_WRITE    8'h02
`define OP_ID_READ        8'h83
`define OP_ID_WRITE       8'h82

// status byte layout
`define SR_BUSY_BIT       0
`define SR_LATCH_BIT      1
`define SR_GUARD_LOW_BIT  2
`define SR_GUARD_HIGH_BIT 3
`define SR_REG_GUARD_BIT  7
`define SR_RESET          8'h00

// block guard codes
`define GUARD_QUARTER     2'h1
`define GUARD_HALF        2'h2
`define GUARD_ALL         2'h3

// command framing
`define BYTES_ONE         3'h1
`define BYTES_STATE_WR    3'h2
`define BYTES_ADDR_END    3'h2
`define BYTES_DATA_START  3'h3
`define BYTES_SAT         3'h4
`define ID_SELECT_BIT     10

// program cycle time and clock rate
`define PROG_TIME_US      4000
`define CLK_FREQ_KHZ      10000

`endif

// File: spi_eeprom_pkg.sv
package spi_eeprom_pkg;

    typedef enum logic {
        PROG_IDLE,
        PROG_RUN
    } prog_state_t;

    typedef enum logic [1:0] {
        TGT_ARRAY,
        TGT_ID,
        TGT_STATUS
    } prog_target_t;

endpackage : spi_eeprom_pkg

// File: spi_eeprom_dpram.sv
`timescale 1ns/1ps

module spi_eeprom_dpram #(
    parameter int WIDTH = 8,
    parameter int AW    = 6
) (
    // write side
    input  wire logic             wclk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    // read side
    input  wire logic             rclk,
    input  wire logic             re,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    generate
        if (WIDTH < 1 || AW < 1 || AW > 20) begin : g_bad_size
            $error("dpram size out of range");
        end
    endgenerate

    logic [WIDTH-1:0] mem [2**AW];

    always_ff @(posedge wclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read, no reset: contents are non-volatile
    always_ff @(posedge rclk) begin
        if (re) begin
            rdata <= mem[raddr];
        end
    end

endmodule : spi_eeprom_dpram

// File: spi_eeprom_instruction_engine.sv
`timescale 1ns/1ps
`include "spi_eeprom_params.svh"

module spi_eeprom_instruction_engine
    import spi_eeprom_pkg::*;
#(
    parameter int ARRAY_AW    = 15,
    parameter int PAGE_AW     = 6,
    parameter int PROG_CYCLES = `PROG_TIME_US * (`CLK_FREQ_KHZ / 1000)
) (
    // system
    input  wire logic clk,
    input  wire logic rst_n,
    // spi link
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic mosi,
    output logic      miso,
    output logic      miso_oe,
    // state view
    output logic      program_busy_flag,
    output logic      write_enable_latch
);

    localparam int CNT_W  = $clog2(PROG_CYCLES + 1);
    localparam int PAGE_N = 2**PAGE_AW;

    generate
        if (ARRAY_AW > 15 || ARRAY_AW <= PAGE_AW + 1 || PAGE_AW > 6) begin : g_bad_geom
            $error("array geometry not supported");
        end
        if (PROG_CYCLES < PAGE_N + 4) begin : g_bad_time
            $error("program cycle shorter than page copy");
        end
    endgenerate

    // clk domain state
    prog_state_t         state_reg;
    prog_target_t        target_reg;
    logic                busy_reg;
    logic                latch_reg;
    logic                srg_reg;
    logic [1:0]          bp_reg;
    logic [CNT_W-1:0]    prog_cnt_reg;
    logic [PAGE_AW:0]    cp_idx_reg;
    logic [PAGE_AW-1:0]  cp_d_reg;
    logic                cp_valid_reg;
    logic [ARRAY_AW-PAGE_AW-1:0] page_reg;
    logic [PAGE_N-1:0]   mask_cap_reg;
    logic [7:0]          sr_new_reg;
    logic                cs_s1_reg;
    logic                cs_s2_reg;
    logic                cs_d_reg;
    logic                seen_tgl_reg;
    logic [7:0]          status_word;

    // sclk domain state, except buf_rdata, which is read out on clk
    logic                in_frame_reg;
    logic                send_reg;
    logic [2:0]          bit_cnt_reg;
    logic [2:0]          byte_cnt_reg;
    logic [6:0]          shift_reg;
    logic [7:0]          opcode_reg;
    logic [15:0]         addr_reg;
    logic [7:0]          stat_in_reg;
    logic [PAGE_N-1:0]   mask_reg;
    logic                frame_tgl_reg;
    logic [7:0]          stat_s1_reg;
    logic [7:0]          stat_s2_reg;
    logic [7:0]          tx_reg;
    logic                miso_reg;
    logic                miso_oe_reg;
    logic [7:0]          arr_rdata;
    logic [7:0]          id_rdata;
    logic [7:0]          buf_rdata;

    always_comb begin
        status_word                     = `SR_RESET;
        status_word[`SR_BUSY_BIT]       = busy_reg;
        status_word[`SR_LATCH_BIT]      = latch_reg;
        status_word[`SR_GUARD_LOW_BIT]  = bp_reg[0];
        status_word[`SR_GUARD_HIGH_BIT] = bp_reg[1];
        status_word[`SR_REG_GUARD_BIT]  = srg_reg;
    end

    // deselect clears frame state at once, so output drive stops without an sclk edge
    wire frame_rst_n = rst_n & ~cs_n;

    // sclk rising edge: command intake
    wire [2:0]  bit_now    = in_frame_reg ? bit_cnt_reg : 3'h0;
    wire [2:0]  byte_now   = in_frame_reg ? byte_cnt_reg : 3'h0;
    wire [7:0]  rx_byte    = {shift_reg, mosi};
    wire        byte_done  = (bit_now == 3'h7);
    wire        op_done    = byte_done && (byte_now == 3'h0);
    wire [7:0]  op_now     = op_done ? rx_byte : opcode_reg;
    wire        busy_s     = stat_s2_reg[`SR_BUSY_BIT];
    wire        addr_hi    = byte_done && (byte_now == `BYTES_ONE);
    wire        addr_done  = byte_done && (byte_now == `BYTES_ADDR_END);
    wire        data_done  = byte_done && (byte_now >= `BYTES_DATA_START);
    wire [15:0] addr_full  = {addr_reg[15:8], rx_byte};
    wire [15:0] addr_inc   = addr_reg + 16'h1;
    wire        op_arr_rd  = (op_now == `OP_ARRAY_READ);
    wire        op_id_rd   = (op_now == `OP_ID_READ);
    wire        op_sr_rd   = (op_now == `OP_STATE_READ);
    wire        op_wr      = (op_now == `OP_ARRAY_WRITE) || (op_now == `OP_ID_WRITE);
    // reads refused while busy; a status read is not
    wire        rd_go      = (op_arr_rd || op_id_rd) && !busy_s && (addr_done || data_done);
    wire [15:0] rd_addr    = addr_done ? addr_full : addr_inc;
    wire        buf_we     = op_wr && data_done && !busy_s;
    wire [15:0] addr_wrap  = {addr_reg[15:PAGE_AW], PAGE_AW'(addr_reg[PAGE_AW-1:0] + 1'h1)};
    wire [2:0]  byte_next  = !byte_done ? byte_now :
                             (byte_now == `BYTES_SAT) ? `BYTES_SAT : 3'(byte_now + 3'h1);
    wire [15:0] addr_next  = addr_hi   ? {rx_byte, addr_reg[7:0]} :
                             addr_done ? addr_full :
                             (rd_go && data_done) ? addr_inc :
                             buf_we    ? addr_wrap : addr_reg;
    wire [PAGE_N-1:0] mask_keep = in_frame_reg ? mask_reg : '0;
    wire [PAGE_N-1:0] mask_set  = buf_we ? (PAGE_N'(1) << addr_reg[PAGE_AW-1:0]) : '0;
    wire        send_next  = byte_done && (op_sr_rd || rd_go);

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            in_frame_reg <= 1'h0;
            send_reg     <= 1'h0;
        end else begin
            in_frame_reg <= 1'h1;
            send_reg     <= send_next;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg   <= 3'h0;
            byte_cnt_reg  <= 3'h0;
            shift_reg     <= 7'h00;
            opcode_reg    <= 8'h00;
            addr_reg      <= 16'h0000;
            mask_reg      <= '0;
            frame_tgl_reg <= 1'h0;
        end else begin
            bit_cnt_reg   <= 3'(bit_now + 3'h1);
            byte_cnt_reg  <= byte_next;
            shift_reg     <= rx_byte[6:0];
            opcode_reg    <= op_now;
            addr_reg      <= addr_next;
            mask_reg      <= mask_keep | mask_set;
            frame_tgl_reg <= frame_tgl_reg ^ ~in_frame_reg;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            stat_in_reg <= 8'h00;
            stat_s1_reg <= `SR_RESET;
            stat_s2_reg <= `SR_RESET;
        end else begin
            stat_s1_reg <= status_word;
            stat_s2_reg <= stat_s1_reg;
            if (addr_hi) begin
                stat_in_reg <= rx_byte;
            end
        end
    end

    // sclk falling edge: data out
    wire [7:0] tx_pick = (opcode_reg == `OP_STATE_READ) ? stat_s2_reg :
                         (opcode_reg == `OP_ID_READ)    ? id_rdata : arr_rdata;

    always_ff @(negedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            tx_reg      <= 8'h00;
            miso_reg    <= 1'h0;
            miso_oe_reg <= 1'h0;
        end else if (send_reg) begin
            tx_reg      <= {tx_pick[6:0], 1'h0};
            miso_reg    <= tx_pick[7];
            miso_oe_reg <= 1'h1;
        end else begin
            tx_reg      <= {tx_reg[6:0], 1'h0};
            miso_reg    <= tx_reg[7];
        end
    end

    assign miso               = miso_reg;
    assign miso_oe            = miso_oe_reg;
    assign program_busy_flag  = busy_reg;
    assign write_enable_latch = latch_reg;

    // clk domain: command execution
    // sclk-side registers stand still while deselected, so they are read
    // only on the synchronised deselect edge; the toggle marks a fresh frame
    wire cs_rise    = cs_s2_reg && !cs_d_reg;
    wire new_frame  = cs_rise && (frame_tgl_reg != seen_tgl_reg);
    wire whole      = (bit_cnt_reg == 3'h0);
    wire dec_set    = new_frame && whole && (opcode_reg == `OP_LATCH_SET) && (byte_cnt_reg == `BYTES_ONE);
    wire dec_clear  = new_frame && whole && (opcode_reg == `OP_LATCH_CLEAR) && (byte_cnt_reg == `BYTES_ONE);
    wire dec_sr_wr  = new_frame && whole && (opcode_reg == `OP_STATE_WRITE) && (byte_cnt_reg == `BYTES_STATE_WR);
    wire dec_arr_wr = new_frame && whole && (opcode_reg == `OP_ARRAY_WRITE) && (byte_cnt_reg == `BYTES_SAT);
    wire dec_id_wr  = new_frame && whole && (opcode_reg == `OP_ID_WRITE) && (byte_cnt_reg == `BYTES_SAT)
                      && !addr_reg[`ID_SELECT_BIT];
    wire page_guarded = (bp_reg == `GUARD_ALL)
                     || ((bp_reg == `GUARD_HALF) && addr_reg[ARRAY_AW-1])
                     || ((bp_reg == `GUARD_QUARTER) && (addr_reg[ARRAY_AW-1:ARRAY_AW-2] == 2'h3));
    wire may_write  = latch_reg && !busy_reg;
    wire start_arr  = dec_arr_wr && may_write && !page_guarded;
    wire start_id   = dec_id_wr && may_write && (bp_reg != `GUARD_ALL);
    wire start_sr   = dec_sr_wr && may_write;
    wire start_any  = start_arr || start_id || start_sr;
    wire end_now    = (state_reg == PROG_RUN) && (prog_cnt_reg == CNT_W'(PROG_CYCLES - 1));
    wire cp_run     = (state_reg == PROG_RUN) && !cp_idx_reg[PAGE_AW] && (target_reg != TGT_STATUS);
    wire cp_hit     = cp_valid_reg && mask_cap_reg[cp_d_reg];
    wire arr_we     = cp_hit && (target_reg == TGT_ARRAY);
    wire id_we      = cp_hit && (target_reg == TGT_ID);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s1_reg    <= 1'h1;
            cs_s2_reg    <= 1'h1;
            cs_d_reg     <= 1'h1;
            seen_tgl_reg <= 1'h0;
        end else begin
            cs_s1_reg    <= cs_n;
            cs_s2_reg    <= cs_s1_reg;
            cs_d_reg     <= cs_s2_reg;
            if (cs_rise) begin
                seen_tgl_reg <= frame_tgl_reg;
            end
        end
    end

    // latch: clear also honoured while busy and leaves the cycle running
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= 1'h0;
        end else if (dec_set && !busy_reg) begin
            latch_reg <= 1'h1;
        end else if (dec_clear || end_now) begin
            latch_reg <= 1'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= PROG_IDLE;
            busy_reg     <= 1'h0;
            prog_cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                PROG_IDLE: begin
                    if (start_any) begin
                        state_reg    <= PROG_RUN;
                        busy_reg     <= 1'h1;
                        prog_cnt_reg <= '0;
                    end
                end
                PROG_RUN: begin
                    prog_cnt_reg <= CNT_W'(prog_cnt_reg + 1'h1);
                    if (end_now) begin
                        state_reg <= PROG_IDLE;
                        busy_reg  <= 1'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            target_reg   <= TGT_ARRAY;
            page_reg     <= '0;
            mask_cap_reg <= '0;
            sr_new_reg   <= 8'h00;
        end else if (start_any) begin
            target_reg   <= start_sr ? TGT_STATUS : (start_id ? TGT_ID : TGT_ARRAY);
            page_reg     <= addr_reg[ARRAY_AW-1:PAGE_AW];
            mask_cap_reg <= mask_reg;
            sr_new_reg   <= stat_in_reg;
        end
    end

    // page copy runs in the first cycles of the program period; only flagged
    // bytes are replaced, so untouched bytes of the page keep their contents
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cp_idx_reg   <= '0;
            cp_d_reg     <= '0;
            cp_valid_reg <= 1'h0;
        end else begin
            cp_idx_reg   <= start_any ? '0 : (cp_run ? (PAGE_AW+1)'(cp_idx_reg + 1'h1) : cp_idx_reg);
            cp_d_reg     <= cp_idx_reg[PAGE_AW-1:0];
            cp_valid_reg <= cp_run;
        end
    end

    // non-volatile guard bits take effect at the very end of the cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            srg_reg <= 1'h0;
            bp_reg  <= 2'h0;
        end else if (end_now && (target_reg == TGT_STATUS)) begin
            srg_reg <= sr_new_reg[`SR_REG_GUARD_BIT];
            bp_reg  <= {sr_new_reg[`SR_GUARD_HIGH_BIT], sr_new_reg[`SR_GUARD_LOW_BIT]};
        end
    end

    // storage
    spi_eeprom_dpram #(.WIDTH(8), .AW(PAGE_AW)) u_page_buf (
        .wclk  (sclk),
        .we    (buf_we),
        .waddr (addr_reg[PAGE_AW-1:0]),
        .wdata (rx_byte),
        .rclk  (clk),
        .re    (cp_run),
        .raddr (cp_idx_reg[PAGE_AW-1:0]),
        .rdata (buf_rdata)
    );

    // erase-then-program leaves the new byte, so one write stands for both
    spi_eeprom_dpram #(.WIDTH(8), .AW(ARRAY_AW)) u_array (
        .wclk  (clk),
        .we    (arr_we),
        .waddr ({page_reg, cp_d_reg}),
        .wdata (buf_rdata),
        .rclk  (sclk),
        .re    (rd_go && op_arr_rd),
        .raddr (rd_addr[ARRAY_AW-1:0]),
        .rdata (arr_rdata)
    );

    // low address bits only; running past the page end is the host's to avoid
    spi_eeprom_dpram #(.WIDTH(8), .AW(PAGE_AW)) u_id_page (
        .wclk  (clk),
        .we    (id_we),
        .waddr (cp_d_reg),
        .wdata (buf_rdata),
        .rclk  (sclk),
        .re    (rd_go && op_id_rd),
        .raddr (rd_addr[PAGE_AW-1:0]),
        .rdata (id_rdata)
    );

    // checks
    sequence s_frame_end;
        cs_rise;
    endsequence

    sequence s_prog_start;
        start_any ##1 busy_reg;
    endsequence

    a_latch_set: assert property (@(posedge clk) disable iff (!rst_n)
        s_frame_end ##0 (dec_set && !busy_reg) |=> latch_reg)
        else $error("latch not set after set command");

    a_latch_clear: assert property (@(posedge clk) disable iff (!rst_n)
        s_frame_end ##0 (dec_clear && !end_now) |=> !latch_reg && (busy_reg == $past(busy_reg)))
        else $error("latch clear wrong or disturbed program");

    a_state_accept: assert property (@(posedge clk) disable iff (!rst_n)
        dec_sr_wr && !latch_reg && !busy_reg |=> !busy_reg)
        else $error("status write accepted without latch");

    a_guard_update: assert property (@(posedge clk) disable iff (!rst_n)
        !$stable(bp_reg) |-> $past(end_now && (target_reg == TGT_STATUS)) && !busy_reg)
        else $error("guard bits changed before program end");

    a_busy_ignore: assert property (@(posedge clk) disable iff (!rst_n)
        s_frame_end ##0 (busy_reg && !end_now) |=> busy_reg && $stable(target_reg) && $stable(page_reg))
        else $error("command taken while busy");

    a_page_guard: assert property (@(posedge clk) disable iff (!rst_n)
        dec_arr_wr && page_guarded && !busy_reg |=> !busy_reg)
        else $error("write to guarded page accepted");

    a_id_guard: assert property (@(posedge clk) disable iff (!rst_n)
        dec_id_wr && (bp_reg == `GUARD_ALL) && !busy_reg |=> !busy_reg)
        else $error("id write accepted with all guarded");

    a_busy_hold: assert property (@(posedge clk) disable iff (!rst_n)
        s_prog_start |-> busy_reg[*8])
        else $error("busy dropped early");

    a_busy_length: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(busy_reg) |-> $past(prog_cnt_reg) == CNT_W'(PROG_CYCLES - 1))
        else $error("program cycle length wrong");

    a_latch_drop: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(busy_reg) |-> !latch_reg)
        else $error("latch still set after program");

endmodule : spi_eeprom_instruction_engine

// File: spi_host_model.sv
`timescale 1ns/1ps

module spi_host_model (
    // spi link
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    logic [7:0] tx [$];
    logic [7:0] rx [$];
    logic       oe_seen;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // mode 0 at 30 ns a bit; the clock stands low outside frames
    task automatic frame(input int nbytes);
        logic [7:0] r;
        rx = {};
        oe_seen = 1'b0;
        #7 cs_n = 1'b0;
        for (int k = 0; k < nbytes; k++) begin
            for (int i = 7; i >= 0; i--) begin
                mosi = (k < tx.size()) ? tx[k][i] : 1'b0;
                #15 r = {r[6:0], miso};
                oe_seen = oe_seen | miso_oe;
                sclk = 1'b1;
                #15 sclk = 1'b0;
            end
            rx.push_back(r);
        end
        // deselect only at a byte boundary; the gap covers the decoder's sync delay
        #15 cs_n = 1'b1;
        mosi = ~mosi;
        #500;
    endtask : frame
endmodule : spi_host_model

// File: test_spi_eeprom_instruction_engine.sv
`timescale 1ns/1ps
`include "spi_eeprom_params.svh"

module test_spi_eeprom_instruction_engine;
    localparam int PROG = 200;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    wire         sclk, cs_n, mosi, miso, miso_oe, busy, latch;
    int          fail_count = 0;
    int          compares = 0;
    logic [7:0]  mem [logic [14:0]];
    logic [7:0]  idm [64];
    logic [1:0]  g = 2'h0;
    logic        sg = 1'b0;
    logic [15:0] a;

    spi_eeprom_instruction_engine #(.PROG_CYCLES(PROG)) i_dut (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .miso_oe(miso_oe), .program_busy_flag(busy), .write_enable_latch(latch));
    spi_host_model i_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

    always #50 clk = ~clk;

    task automatic print_verdict;
        $display("counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cmd1(input logic [7:0] op);
        i_host.tx = '{op};
        i_host.frame(1);
    endtask : cmd1

    // expected status byte; b6..b4 always read 0
    function automatic logic [7:0] stat_exp(input logic b, input logic l);
        return {sg, 3'h0, g, l, b};
    endfunction : stat_exp

    // page write wraps inside the 64-byte page
    function automatic logic [14:0] page_slot(input logic [15:0] ad, input int k);
        return {ad[14:6], 6'(ad + k)};
    endfunction : page_slot

    task automatic stat_rd(input logic [7:0] e);
        i_host.tx = '{`OP_STATE_READ};
        i_host.frame(3);
        chk(i_host.rx[1], e);
        chk(i_host.rx[2], e);
        chk(miso_oe, 1'b0);
    endtask : stat_rd

    // only a write that really ran leaves a busy period to wait out
    task automatic waitb;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < PROG + 100) begin
            @(posedge clk);
            n++;
        end
        if (busy !== 1'b0) begin
            fail_count++;
            print_verdict();
        end
        if (n > 0) chk(latch, 1'b0);
    endtask : waitb

    task automatic rd(input logic [7:0] op, input logic [15:0] ad, input int n);
        logic [7:0] e;
        i_host.tx = '{op, ad[15:8], ad[7:0]};
        i_host.frame(3 + n);
        for (int k = 0; k < n; k++) begin
            e = (op == `OP_ARRAY_READ) ? mem[15'(ad + k)] : idm[6'(ad + k)];
            chk(i_host.rx[3 + k], e);
        end
        chk(i_host.oe_seen, 1'b1);
    endtask : rd

    task automatic wr(input logic [7:0] op, input logic [15:0] ad, input int n, input bit ok, input bit sl);
        logic [7:0] d;
        if (sl) begin
            cmd1(`OP_LATCH_SET);
            chk(latch, 1'b1);
        end
        i_host.tx = '{op, ad[15:8], ad[7:0]};
        for (int k = 0; k < n; k++) begin
            d = (k == 0 && n > 1) ? 8'hFF : 8'($urandom);
            i_host.tx.push_back(d);
            if (ok && op == `OP_ARRAY_WRITE) mem[page_slot(ad, k)] = d;
            if (ok && op == `OP_ID_WRITE) idm[6'(ad + k)] = d;
        end
        i_host.frame(3 + n);
        chk(busy, ok);
    endtask : wr

    task automatic swr(input logic [7:0] v);
        cmd1(`OP_LATCH_SET);
        i_host.tx = '{`OP_STATE_WRITE, v};
        i_host.frame(2);
        stat_rd(stat_exp(1'b1, 1'b1));
        waitb();
        sg = v[7];
        g = v[3:2];
        stat_rd(stat_exp(1'b0, 1'b0));
    endtask : swr

    initial begin
        #3000000;
        fail_count++;
        print_verdict();
    end

    initial begin
        void'($urandom(22375));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        stat_rd(8'h00);
        cmd1(`OP_LATCH_SET);
        stat_rd(8'h02);
        cmd1(`OP_LATCH_CLEAR);
        chk(latch, 1'b0);
        i_host.tx = '{`OP_STATE_WRITE, 8'h8C};
        i_host.frame(2);
        chk(busy, 1'b0);
        wr(`OP_ARRAY_WRITE, 16'h0000, 1, 1'b0, 1'b0);
        $display("test latch and status done");
        a = {1'b0, 9'($urandom), 6'h3A};
        wr(`OP_ARRAY_WRITE, a, 66, 1'b1, 1'b1);
        stat_rd(8'h03);
        i_host.tx = '{`OP_ARRAY_READ, a[15:8], a[7:0]};
        i_host.frame(5);
        chk(i_host.oe_seen, 1'b0);
        cmd1(`OP_LATCH_CLEAR);
        chk({busy, latch}, 2'b10);
        waitb();
        rd(`OP_ARRAY_READ, {a[15:6], 6'h00}, 64);
        wr(`OP_ARRAY_WRITE, 16'h7FFF, 1, 1'b1, 1'b1);
        waitb();
        wr(`OP_ARRAY_WRITE, 16'h0000, 2, 1'b1, 1'b1);
        waitb();
        rd(`OP_ARRAY_READ, 16'h7FFF, 3);
        $display("test array done");
        wr(`OP_ID_WRITE, 16'h0000, 3, 1'b1, 1'b1);
        waitb();
        rd(`OP_ID_READ, 16'h0000, 3);
        $display("test id page done");
        // every guard code: first protected page refused; page below it accepted under quarter and half guard, refused under full guard
        for (int gi = 1; gi < 4; gi++) begin
            a = (gi == 1) ? 16'h6000 : (gi == 2) ? 16'h4000 : 16'h0000;
            swr({gi[0], 3'h7, 2'(gi), 2'b11});
            wr(`OP_ARRAY_WRITE, a, 1, 1'b0, 1'b1);
            wr(`OP_ARRAY_WRITE, 16'(a - 64) & 16'h7FFF, 1, gi != 3, 1'b1);
            waitb();
            wr(`OP_ID_WRITE, 16'h0005, 1, gi != 3, 1'b1);
            waitb();
        end
        // refused id write under full guard must leave the byte as it was
        rd(`OP_ID_READ, 16'h0005, 1);
        $display("test guard done");
        print_verdict();
    end
endmodule : test_spi_eeprom_instruction_engine
